/* File: atsio_blink.sv */
`timescale 1ns/1ps
module atsio_blink #(
    parameter int HALF_CYC = 2500000
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    output logic      o_phase
);
    localparam int CW = $clog2(HALF_CYC + 1);

    if (HALF_CYC < 1) begin : g_chk
        $error("atsio_blink: HALF_CYC must be at least one");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          phase;
    } atsio_blink_s;

    atsio_blink_s st_q;
    atsio_blink_s st_d;

    // free-running divider; the phase flips once per half period
    always_comb begin
        st_d = st_q;
        if (st_q.cnt == CW'(HALF_CYC - 1)) begin
            st_d.cnt   = '0;
            st_d.phase = ~st_q.phase;
        end else begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_phase = st_q.phase;
endmodule

/* File: atsio_edge_if.sv */
`timescale 1ns/1ps
// filtered level and falling-edge pulse of one trigger input
interface atsio_edge_if;
    logic level;
    logic fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface

/* File: atsio_pkg.sv */
// Notes on behaviour
// - strobe high exactly while overlapped exposure runs
// - single-ended trigger falling edge starts exposure
// - differential pair falling edge starts exposure
// - line active high during valid pixels only
// - each accepted external trigger restarts a 6us echo pulse
// - echo starts at the causing falling edge
// - frame active high across readout, low between
// - ethernet green: blink idle, solid sending, off unlinked
// - ethernet amber blinks; off unlinked or 10/100
// - usb status solid when paused, blinks streaming
// - usb link white, then blue/green/amber/off
package atsio_pkg;
    // core clock rate
    localparam int CLK_KHZ       = 10000;
    // trigger echo pulse width
    localparam int TRIG_OUT_US   = 6;
    localparam int TRIG_OUT_CYC  = TRIG_OUT_US * CLK_KHZ / 1000;
    // indicator blink half period
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
    // power-up white phase of the usb link indicator
    localparam int USB_WHITE_MS  = 1000;
    localparam int USB_WHITE_CYC = USB_WHITE_MS * CLK_KHZ;

    // which source caused the last accepted trigger
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_CC1  = 2'h1;
    localparam logic [1:0] SRC_SE   = 2'h2;
    localparam logic [1:0] SRC_DIFF = 2'h3;

    // usb link indicator colours as {red, green, blue}
    localparam logic [2:0] RGB_OFF   = 3'h0;
    localparam logic [2:0] RGB_WHITE = 3'h7;
    localparam logic [2:0] RGB_BLUE  = 3'h1;
    localparam logic [2:0] RGB_GREEN = 3'h2;
    localparam logic [2:0] RGB_AMBER = 3'h6;

    // usb link indicator phases
    typedef enum logic [1:0] {
        LNK_WHITE = 2'b01,
        LNK_RUN   = 2'b10
    } atsio_lnk_e;
endpackage

/* File: atsio_sva.sv */
`timescale 1ns/1ps
module atsio_sva #(
    parameter int TRIG_CYC = 60
) (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_trig_se,
    input wire logic       i_trig_diff_p,
    input wire logic       i_trig_diff_n,
    input wire logic [2:0] i_src_enable,
    input wire logic       i_overlap_mode,
    input wire logic       i_exposing,
    input wire logic       i_line_pixel_valid,
    input wire logic       i_frame_readout,
    input wire logic       i_eth_link_up,
    input wire logic       i_eth_sending,
    input wire logic       i_eth_gigabit,
    input wire logic       o_strobe_out,
    input wire logic       o_trigger_out,
    input wire logic       o_line_active_out,
    input wire logic       o_frame_active_out,
    input wire logic       o_exposure_start,
    input wire logic       o_eth_green,
    input wire logic       o_eth_amber
);
    int cnt_q;
    int cnt_d;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // echo high time, restarted by each accepted edge because a retrigger restarts the full width
    always_comb begin
        cnt_d = 0;
        if (o_trigger_out) begin
            cnt_d = o_exposure_start ? 1 : cnt_q + 1;
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    a_strobe_exposing: assert property (!$past(i_reset) |-> o_strobe_out == $past(i_overlap_mode && i_exposing))
        else $error("strobe mismatch");
    a_line_gated: assert property (!$past(i_reset) |-> o_line_active_out == $past(i_line_pixel_valid && i_frame_readout))
        else $error("line active mismatch");
    a_frame_follows: assert property (!$past(i_reset) |-> o_frame_active_out == $past(i_frame_readout))
        else $error("frame active mismatch");
    a_echo_width: assert property ($fell(o_trigger_out) |-> cnt_q == TRIG_CYC)
        else $error("echo width wrong");
    a_echo_launch: assert property (o_exposure_start |-> o_trigger_out)
        else $error("start without echo");
    a_start_single: assert property (o_exposure_start |=> !o_exposure_start)
        else $error("start longer than one cycle");
    a_se_fall_start: assert property ($fell(i_trig_se) && i_src_enable[1] ##1 !i_trig_se [*3] |-> ##[1:3] o_exposure_start)
        else $error("single-ended fall missed");
    a_diff_fall_start: assert property ($fell(i_trig_diff_p) && i_trig_diff_n && i_src_enable[2]
        ##1 (!i_trig_diff_p && i_trig_diff_n) [*3] |-> ##[1:3] o_exposure_start)
        else $error("differential fall missed");
    a_green_state: assert property (!$past(i_reset) && $past(i_eth_sending) |-> o_eth_green == $past(i_eth_link_up))
        else $error("green indicator wrong");
    a_amber_dark: assert property (!$past(i_reset) && !$past(i_eth_link_up && i_eth_gigabit) |-> !o_eth_amber)
        else $error("amber indicator lit");

    c_start: cover property (o_exposure_start);
    c_strobe: cover property (o_strobe_out);
    c_echo_end: cover property ($fell(o_trigger_out));
endmodule

bind atsio_top atsio_sva #(.TRIG_CYC(TRIG_CYC)) i_atsio_sva (.i_clk(i_clk), .i_reset(i_reset), .i_trig_se(i_trig_se),
    .i_trig_diff_p(i_trig_diff_p), .i_trig_diff_n(i_trig_diff_n), .i_src_enable(i_src_enable),
    .i_overlap_mode(i_overlap_mode), .i_exposing(i_exposing), .i_line_pixel_valid(i_line_pixel_valid),
    .i_frame_readout(i_frame_readout), .i_eth_link_up(i_eth_link_up), .i_eth_sending(i_eth_sending),
    .i_eth_gigabit(i_eth_gigabit), .o_strobe_out(o_strobe_out), .o_trigger_out(o_trigger_out),
    .o_line_active_out(o_line_active_out), .o_frame_active_out(o_frame_active_out),
    .o_exposure_start(o_exposure_start), .o_eth_green(o_eth_green), .o_eth_amber(o_eth_amber));

/* File: atsio_sync.sv */
`timescale 1ns/1ps
module atsio_sync #(
    parameter bit RESET_LEVEL = 1'b1
) (
    input  wire logic   i_clk,
    input  wire logic   i_reset,
    input  wire logic   i_pin,
    atsio_edge_if.src   o_edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic fall;
    } atsio_sync_s;

    localparam atsio_sync_s RST = '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL,
                                    level: RESET_LEVEL, fall: 1'b0};

    atsio_sync_s st_q;
    atsio_sync_s st_d;

    // three stages; a change counts only once stage two and three agree
    always_comb begin
        st_d       = st_q;
        st_d.s1    = i_pin;
        st_d.s2    = st_q.s1;
        st_d.s3    = st_q.s2;
        st_d.fall  = 1'b0;
        if (st_q.s2 == st_q.s3) begin
            st_d.level = st_q.s3;
            st_d.fall  = st_q.level & ~st_q.s3;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_edge.level = st_q.level;
    assign o_edge.fall  = st_q.fall;
endmodule

/* File: atsio_tb_top.sv */
`timescale 1ns/1ps
module atsio_tb_top import atsio_pkg::*;;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [2:0]  fire = 3'h0;
    logic [2:0]  i_src_enable = 3'h7;
    logic [7:0]  lvl = 8'h00; // overlap exposing pixel readout link sending gigabit ready
    logic [3:0]  usb = 4'h0;  // streaming connected super fault
    logic        se, cc1, dp, dn, strobe, trig, line, frame, start, green, amber, stat;
    logic [1:0]  src;
    logic [2:0]  rgb;
    int          failures = 0;
    int          tests_run = 0;
    logic [13:0] rows [4] = '{14'h3f7d, 14'h1980, 14'h274d, 14'h3c38};
    logic [2:0]  link_in [4] = '{3'h0, 3'h6, 3'h4, 3'h7};
    logic [2:0]  link_exp [4] = '{RGB_OFF, RGB_BLUE, RGB_GREEN, RGB_AMBER};

    // short blink and white phases keep the run brief
    atsio_top #(.BLINK_CYC(4), .WHITE_CYC(8)) i_atsio_top (.i_clk(i_clk), .i_reset(i_reset), .i_trig_se(se),
        .i_trig_diff_p(dp), .i_trig_diff_n(dn), .i_cc1(cc1), .i_src_enable(i_src_enable), .i_overlap_mode(lvl[7]),
        .i_exposing(lvl[6]), .i_line_pixel_valid(lvl[5]), .i_frame_readout(lvl[4]), .i_eth_link_up(lvl[3]),
        .i_eth_sending(lvl[2]), .i_eth_gigabit(lvl[1]), .i_usb_ready(lvl[0]), .i_usb_streaming(usb[3]),
        .i_usb_connected(usb[2]), .i_usb_super(usb[1]), .i_usb_fault(usb[0]), .o_strobe_out(strobe),
        .o_trigger_out(trig), .o_line_active_out(line), .o_frame_active_out(frame), .o_exposure_start(start),
        .o_trig_source(src), .o_eth_green(green), .o_eth_amber(amber), .o_usb_status_green(stat),
        .o_usb_link_rgb(rgb));
    atsio_trig_model i_atsio_trig_model (.i_clk(i_clk), .i_fire(fire), .o_cc1(cc1), .o_se(se), .o_diff_p(dp),
        .o_diff_n(dn));

    // 10 MHz core clock
    always #50 i_clk = ~i_clk;

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // one request, then watch until the echo ends; the bound also catches a stuck echo
    task automatic fire_src(input logic [2:0] f, input logic [1:0] exp_src, input logic [7:0] exp_n);
        int n;
        int w;
        int s;
        n = 0;
        w = 0;
        s = 0;
        @(posedge i_clk);
        fire <= f;
        @(posedge i_clk);
        fire <= 3'h0;
        while (n < 150 && (w == 0 || trig === 1'b1)) begin
            tick(1);
            n++;
            w += int'(trig === 1'b1);
            s += int'(start === 1'b1);
        end
        check("starts", 8'(s), exp_n);
        check("echo width", 8'(w), exp_n * 8'(TRIG_OUT_CYC));
        if (exp_n != 8'h0) begin
            check("source", {6'h0, src}, {6'h0, exp_src});
        end
        $display("test trigger %h done", f);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        int g;
        int a;
        int u;
        tick(2);
        check("rgb in reset", {5'h0, rgb}, {5'h0, RGB_WHITE});
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        tick(2);
        check("rgb after reset", {5'h0, rgb}, {5'h0, RGB_WHITE});
        $display("test reset done");
        // level outputs and steady indicator states
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            lvl <= rows[i][13:6];
            tick(2);
            check("levels", {2'h0, strobe, line, frame, green, amber, stat}, {2'h0, rows[i][5:0]});
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            usb <= {1'b0, link_in[i]};
            tick(2);
            check("usb link", {5'h0, rgb}, {5'h0, link_exp[i]});
        end
        $display("test levels done");
        // idle link, gigabit, streaming: all three indicators must blink
        @(posedge i_clk);
        lvl <= 8'h1b;
        usb <= 4'h8;
        g = 0;
        a = 0;
        u = 0;
        tick(2);
        for (int i = 0; i < 16; i++) begin
            tick(1);
            g += int'(green === 1'b1);
            a += int'(amber === 1'b1);
            u += int'(stat === 1'b1);
        end
        check("green blinks", 8'(g > 0 && g < 16), 8'h1);
        check("amber blinks", 8'(a > 0 && a < 16), 8'h1);
        check("status blinks", 8'(u > 0 && u < 16), 8'h1);
        $display("test blink done");
        fire_src(3'h1, SRC_CC1, 8'h1);
        fire_src(3'h2, SRC_SE, 8'h1);
        fire_src(3'h4, SRC_DIFF, 8'h1);
        fire_src(3'h7, SRC_CC1, 8'h1);
        @(posedge i_clk);
        i_src_enable <= 3'h5;
        fire_src(3'h2, SRC_NONE, 8'h0);
        close_out();
    end
endmodule

/* File: atsio_top.sv */
`timescale 1ns/1ps
module atsio_top
    import atsio_pkg::*;
#(
    parameter int TRIG_CYC  = TRIG_OUT_CYC,
    parameter int BLINK_CYC = BLINK_HALF_CYC,
    parameter int WHITE_CYC = USB_WHITE_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // trigger pins and the host trigger line, all asynchronous
    input  wire logic       i_trig_se,
    input  wire logic       i_trig_diff_p,
    input  wire logic       i_trig_diff_n,
    input  wire logic       i_cc1,
    // per-source enables: bit0 cc1, bit1 single-ended, bit2 differential
    input  wire logic [2:0] i_src_enable,
    // sensor timing, on the core clock
    input  wire logic       i_overlap_mode,
    input  wire logic       i_exposing,
    input  wire logic       i_line_pixel_valid,
    input  wire logic       i_frame_readout,
    // ethernet link state
    input  wire logic       i_eth_link_up,
    input  wire logic       i_eth_sending,
    input  wire logic       i_eth_gigabit,
    // usb state
    input  wire logic       i_usb_ready,
    input  wire logic       i_usb_streaming,
    input  wire logic       i_usb_connected,
    input  wire logic       i_usb_super,
    input  wire logic       i_usb_fault,
    // pins and status
    output logic            o_strobe_out,
    output logic            o_trigger_out,
    output logic            o_line_active_out,
    output logic            o_frame_active_out,
    output logic            o_exposure_start,
    output logic [1:0]      o_trig_source,
    output logic            o_eth_green,
    output logic            o_eth_amber,
    output logic            o_usb_status_green,
    output logic [2:0]      o_usb_link_rgb
);
    localparam int TCW = $clog2(TRIG_CYC + 1);
    localparam int WCW = $clog2(WHITE_CYC + 1);

    // refuse widths the counters cannot serve
    if (TRIG_CYC < 1 || WHITE_CYC < 1 || BLINK_CYC < 1) begin : g_chk
        $error("atsio_top: timing counts must be at least one");
    end

    typedef struct packed {
        logic           diff_level;
        logic           strobe;
        logic           trig_out;
        logic [TCW-1:0] trig_cnt;
        logic           exp_start;
        logic [1:0]     src;
        logic           line_act;
        logic           frame_act;
        logic           eth_g;
        logic           eth_a;
        logic           usb_stat;
        logic [2:0]     usb_rgb;
        atsio_lnk_e     lnk;
        logic [WCW-1:0] white_cnt;
    } atsio_top_s;

    // idle trigger lines rest high; the differential pair idles p=1, n=0
    localparam atsio_top_s RST = '{
        diff_level: 1'b1,
        strobe:     1'b0,
        trig_out:   1'b0,
        trig_cnt:   '0,
        exp_start:  1'b0,
        src:        SRC_NONE,
        line_act:   1'b0,
        frame_act:  1'b0,
        eth_g:      1'b0,
        eth_a:      1'b0,
        usb_stat:   1'b0,
        usb_rgb:    RGB_WHITE,
        lnk:        LNK_WHITE,
        white_cnt:  '0
    };

    atsio_top_s st_q;
    atsio_top_s st_d;

    atsio_edge_if e_se ();
    atsio_edge_if e_dp ();
    atsio_edge_if e_dn ();
    atsio_edge_if e_cc ();

    logic blink;

    // every trigger line gets its own synchroniser
    atsio_sync #(.RESET_LEVEL(1'b1)) u_sync_se (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (i_trig_se),
        .o_edge  (e_se)
    );
    atsio_sync #(.RESET_LEVEL(1'b1)) u_sync_dp (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (i_trig_diff_p),
        .o_edge  (e_dp)
    );
    atsio_sync #(.RESET_LEVEL(1'b0)) u_sync_dn (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (i_trig_diff_n),
        .o_edge  (e_dn)
    );
    atsio_sync #(.RESET_LEVEL(1'b1)) u_sync_cc (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (i_cc1),
        .o_edge  (e_cc)
    );

    // one shared blink phase keeps all indicators flashing in step
    atsio_blink #(.HALF_CYC(BLINK_CYC)) u_blink (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .o_phase (blink)
    );

    // per-source accepted falling edges
    logic fall_cc;
    logic fall_se;
    logic fall_diff;
    logic diff_now;
    logic any_fall;

    always_comb begin
        // the pair only counts as a valid level when the legs disagree,
        // so a common-mode glitch on both legs cannot fake an edge
        diff_now  = (e_dp.level != e_dn.level) ? e_dp.level : st_q.diff_level;
        fall_diff = i_src_enable[2] & st_q.diff_level & ~diff_now;
        fall_se   = i_src_enable[1] & e_se.fall;
        fall_cc   = i_src_enable[0] & e_cc.fall;
        any_fall  = fall_cc | fall_se | fall_diff;
    end

    // main next-state logic
    always_comb begin
        st_d            = st_q;
        st_d.diff_level = diff_now;

        // exposure start and source report; cc1 wins a simultaneous edge
        st_d.exp_start = any_fall;
        if (fall_cc) begin
            st_d.src = SRC_CC1;
        end else if (fall_se) begin
            st_d.src = SRC_SE;
        end else if (fall_diff) begin
            st_d.src = SRC_DIFF;
        end

        // echo pulse: a new edge restarts the full width of a pulse already
        // running, so a retriggered pulse ends one full width after the last edge
        if (any_fall) begin
            st_d.trig_out = 1'b1;
            st_d.trig_cnt = TCW'(TRIG_CYC - 1);
        end else if (st_q.trig_cnt != '0) begin
            st_d.trig_cnt = st_q.trig_cnt - TCW'(1);
        end else begin
            st_d.trig_out = 1'b0;
        end

        // strobe only reports exposure in overlapped continuous mode
        st_d.strobe = i_overlap_mode & i_exposing;

        // readout valid outputs follow the sensor timing
        st_d.line_act  = i_line_pixel_valid & i_frame_readout;
        st_d.frame_act = i_frame_readout;

        // ethernet green: off unlinked, solid sending, blink idle
        if (!i_eth_link_up) begin
            st_d.eth_g = 1'b0;
        end else if (i_eth_sending) begin
            st_d.eth_g = 1'b1;
        end else begin
            st_d.eth_g = blink;
        end

        // ethernet amber blinks only on a gigabit link
        st_d.eth_a = i_eth_link_up & i_eth_gigabit & blink;

        // usb status: dark until ready, solid when paused, blink streaming
        if (!i_usb_ready) begin
            st_d.usb_stat = 1'b0;
        end else if (i_usb_streaming) begin
            st_d.usb_stat = blink;
        end else begin
            st_d.usb_stat = 1'b1;
        end

        // usb link indicator
        unique case (st_q.lnk)
            LNK_WHITE: begin
                st_d.usb_rgb = RGB_WHITE;
                if (st_q.white_cnt == WCW'(WHITE_CYC - 1)) begin
                    st_d.lnk = LNK_RUN;
                end else begin
                    st_d.white_cnt = st_q.white_cnt + WCW'(1);
                end
            end
            LNK_RUN: begin
                // a fault outranks the port speed report
                if (!i_usb_connected) begin
                    st_d.usb_rgb = RGB_OFF;
                end else if (i_usb_fault) begin
                    st_d.usb_rgb = RGB_AMBER;
                end else if (i_usb_super) begin
                    st_d.usb_rgb = RGB_BLUE;
                end else begin
                    st_d.usb_rgb = RGB_GREEN;
                end
            end
            default: begin
                // illegal code: recover through the power-up phase
                st_d.lnk       = LNK_WHITE;
                st_d.white_cnt = '0;
                st_d.usb_rgb   = RGB_WHITE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= RST;
        end else begin
            st_q <= st_d;
        end
    end

    // all outputs straight from the state register
    assign o_strobe_out       = st_q.strobe;
    assign o_trigger_out      = st_q.trig_out;
    assign o_line_active_out  = st_q.line_act;
    assign o_frame_active_out = st_q.frame_act;
    assign o_exposure_start   = st_q.exp_start;
    assign o_trig_source      = st_q.src;
    assign o_eth_green        = st_q.eth_g;
    assign o_eth_amber        = st_q.eth_a;
    assign o_usb_status_green = st_q.usb_stat;
    assign o_usb_link_rgb     = st_q.usb_rgb;
endmodule

/* File: atsio_trig_model.sv */
`timescale 1ns/1ps
module atsio_trig_model #(
    parameter int LOW_CYC = 6
) (
    input  wire logic       i_clk,
    input  wire logic [2:0] i_fire,
    output logic            o_cc1,
    output logic            o_se,
    output logic            o_diff_p,
    output logic            o_diff_n
);
    logic [2:0] low_q = 3'h0;
    int         cnt_q = 0;

    // held low long enough for the synchroniser, so each request is one clean fall and rise
    always @(posedge i_clk) begin
        if (i_fire != 3'h0) begin
            low_q <= i_fire;
            cnt_q <= LOW_CYC;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end else begin
            low_q <= 3'h0;
        end
    end

    // cc1, single-ended and the positive leg idle high between requests; the negative leg idles low
    assign o_cc1    = ~low_q[0];
    assign o_se     = ~low_q[1];
    assign o_diff_p = ~low_q[2];
    assign o_diff_n = low_q[2];  // negative leg is the complement
endmodule
